// ---- core/timer_irq_mask_flag_unit.sv ----
// interrupt mask and flag registers with request gating for four 16-bit timer units
`timescale 1ns/100ps
module timer_irq_mask_flag_unit
   import timer_irq_pkg::*;
#(
   parameter logic [15:0] P_OVF_MAX_MODES    = timer_irq_pkg::OVF_MAX_MODES,
   parameter logic [15:0] P_OVF_TOP_MODES    = timer_irq_pkg::OVF_TOP_MODES,
   parameter logic [15:0] P_OVF_BOTTOM_MODES = timer_irq_pkg::OVF_BOTTOM_MODES,
   parameter logic [15:0] P_ICR_TOP_MODES    = timer_irq_pkg::ICR_TOP_MODES
) (
   input  wire logic                                          ref_clk_in,     // system clock, 10 MHz
   input  wire logic                                          reset_in,       // async reset, active high
   input  wire timer_irq_pkg::bus_req_t                       bus_in,         // register port request
   output logic [7:0]                                         rd_data_out,    // read data, cycle after read
   input  wire logic                                          glob_irq_en_in, // global interrupt enable
   input  wire timer_irq_pkg::timer_evt_t [timer_irq_pkg::N_TIMERS-1:0] evt_in, // timer event strobes
   input  wire logic [timer_irq_pkg::N_TIMERS-1:0][timer_irq_pkg::N_SRC-1:0] vec_ack_in, // vector executed
   output logic [timer_irq_pkg::N_TIMERS-1:0][timer_irq_pkg::N_SRC-1:0] irq_req_out, // interrupt requests
   output logic                                               irq_out         // lost-event interrupt
);
   import timer_irq_pkg::*;

   top_state_t st;
   top_state_t next_st;

   logic [N_TIMERS-1:0][N_SRC-1:0] set_vec;
   logic [N_TIMERS-1:0][N_SRC-1:0] clr_vec;
   logic [N_TIMERS-1:0][N_SRC-1:0] flag_wr_ones;
   logic [N_TIMERS-1:0]            lost_evt;
   logic [N_TIMERS-1:0]            ovr_status;
   logic [N_TIMERS-1:0]            ovr_mask;
   logic                           ovr_irq;
   logic                           ovr_status_wr;
   logic                           ovr_mask_wr;

   // event decode: what each timer wants to set this cycle
   always_comb begin
      for (int t = 0; t < N_TIMERS; t++) begin
         set_vec[t][SRC_CAP] = evt_in[t].capture_pin
            || (evt_in[t].tick && evt_in[t].at_top
                && P_ICR_TOP_MODES[evt_in[t].waveform_gen_sel]);
         // match seen in one timer clock sets the flag in the next; force strobes are not looked at
         set_vec[t][SRC_CMP_C] = evt_in[t].tick && st.tmr[t].cmp_seen[2];
         set_vec[t][SRC_CMP_B] = evt_in[t].tick && st.tmr[t].cmp_seen[1];
         set_vec[t][SRC_CMP_A] = evt_in[t].tick && st.tmr[t].cmp_seen[0];
         set_vec[t][SRC_OVF] = evt_in[t].tick
            && ((evt_in[t].overflow && P_OVF_MAX_MODES[evt_in[t].waveform_gen_sel])
             || (evt_in[t].at_top && P_OVF_TOP_MODES[evt_in[t].waveform_gen_sel])
             || (evt_in[t].at_bottom && P_OVF_BOTTOM_MODES[evt_in[t].waveform_gen_sel]));
         flag_wr_ones[t] = reg_hit(bus_in.addr, FLAG_OFS[t], bus_in.wr)
            ? from_reg(bus_in.wdata) : '0;
         clr_vec[t] = flag_wr_ones[t] | vec_ack_in[t];
         // an event that finds its flag already up is otherwise silently merged
         lost_evt[t] = |(set_vec[t] & st.tmr[t].flag);
      end
   end

   // next state of all timers and of the read port
   always_comb begin
      next_st = st;
      next_st.rd_data = 8'h00;
      for (int t = 0; t < N_TIMERS; t++) begin
         if (evt_in[t].tick) begin
            next_st.tmr[t].cmp_seen = {evt_in[t].match[2], evt_in[t].match[1], evt_in[t].match[0]};
         end
         // set wins over clear; zero bits written leave flags alone
         next_st.tmr[t].flag = (st.tmr[t].flag & ~clr_vec[t]) | set_vec[t];
         if (reg_hit(bus_in.addr, MASK_OFS[t], bus_in.wr)) begin
            next_st.tmr[t].mask = from_reg(bus_in.wdata);
         end
         // requests follow the registered mask and flag, so a request never races a write
         next_st.tmr[t].req[SRC_CAP]   = glob_irq_en_in && st.tmr[t].mask[SRC_CAP]
                                         && st.tmr[t].flag[SRC_CAP];
         next_st.tmr[t].req[SRC_CMP_C] = glob_irq_en_in && st.tmr[t].mask[SRC_CMP_C]
                                         && st.tmr[t].flag[SRC_CMP_C];
         next_st.tmr[t].req[SRC_CMP_B] = glob_irq_en_in && st.tmr[t].mask[SRC_CMP_B]
                                         && st.tmr[t].flag[SRC_CMP_B];
         next_st.tmr[t].req[SRC_CMP_A] = glob_irq_en_in && st.tmr[t].mask[SRC_CMP_A]
                                         && st.tmr[t].flag[SRC_CMP_A];
         next_st.tmr[t].req[SRC_OVF]   = glob_irq_en_in && st.tmr[t].mask[SRC_OVF]
                                         && st.tmr[t].flag[SRC_OVF];
         if (reg_hit(bus_in.addr, FLAG_OFS[t], bus_in.rd)) begin
            next_st.rd_data = to_reg(st.tmr[t].flag);
         end
         if (reg_hit(bus_in.addr, MASK_OFS[t], bus_in.rd)) begin
            next_st.rd_data = to_reg(st.tmr[t].mask);
         end
      end
      if (reg_hit(bus_in.addr, OVR_STATUS_OFS, bus_in.rd)) begin
         next_st.rd_data = {4'h0, ovr_status};
      end
      if (reg_hit(bus_in.addr, OVR_MASK_OFS, bus_in.rd)) begin
         next_st.rd_data = {4'h0, ovr_mask};
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         for (int t = 0; t < N_TIMERS; t++) begin
            st.tmr[t].mask     <= from_reg(MASK_RESET);
            st.tmr[t].flag     <= from_reg(FLAG_RESET);
            st.tmr[t].cmp_seen <= 3'h0;
            st.tmr[t].req      <= '0;
         end
         st.rd_data <= 8'h00;
      end else begin
         st <= next_st;
      end
   end

   assign ovr_status_wr = reg_hit(bus_in.addr, OVR_STATUS_OFS, bus_in.wr);
   assign ovr_mask_wr   = reg_hit(bus_in.addr, OVR_MASK_OFS, bus_in.wr);

   irq_status_unit #(
      .W (N_TIMERS)
   ) u_lost_events (
      .ref_clk_in   (ref_clk_in),
      .reset_in     (reset_in),
      .set_in       (lost_evt),
      .status_wr_in (ovr_status_wr),
      .mask_wr_in   (ovr_mask_wr),
      .wdata_in     (bus_in.wdata[N_TIMERS-1:0]),
      .status_out   (ovr_status),
      .mask_out     (ovr_mask),
      .irq_out      (ovr_irq)
   );

   always_comb begin
      for (int t = 0; t < N_TIMERS; t++) begin
         irq_req_out[t] = st.tmr[t].req;
      end
   end
   assign rd_data_out = st.rd_data;
   assign irq_out     = ovr_irq;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (reset_in);

   generate
      for (genvar t = 0; t < N_TIMERS; t++) begin : g_chk
         a_cap_req_gate:
            assert property (irq_req_out[t][SRC_CAP] == $past(glob_irq_en_in
                             && st.tmr[t].mask[SRC_CAP] && st.tmr[t].flag[SRC_CAP]))
            else $error("capture request does not follow mask, enable and flag");
         a_cmp_c_req:
            assert property ((glob_irq_en_in && st.tmr[t].mask[SRC_CMP_C] && st.tmr[t].flag[SRC_CMP_C])
                             |=> irq_req_out[t][SRC_CMP_C])
            else $error("compare C request missing");
         a_cmp_b_req:
            assert property (!glob_irq_en_in || !st.tmr[t].mask[SRC_CMP_B]
                             |=> !irq_req_out[t][SRC_CMP_B])
            else $error("compare B request without enable or mask");
         a_cmp_a_req:
            assert property ($rose(irq_req_out[t][SRC_CMP_A])
                             |-> $past(st.tmr[t].flag[SRC_CMP_A] && st.tmr[t].mask[SRC_CMP_A]))
            else $error("compare A request rose without flag and mask");
         a_ovf_req_gate:
            assert property ((glob_irq_en_in && st.tmr[t].mask[SRC_OVF] && st.tmr[t].flag[SRC_OVF])
                             ##1 (glob_irq_en_in && st.tmr[t].mask[SRC_OVF] && st.tmr[t].flag[SRC_OVF])
                             |-> irq_req_out[t][SRC_OVF])
            else $error("overflow request dropped while its cause holds");
         a_cap_pin_set:
            assert property (evt_in[t].capture_pin |=> st.tmr[t].flag[SRC_CAP])
            else $error("capture pin event did not set the capture flag");
         a_cap_top_set:
            assert property (evt_in[t].tick && evt_in[t].at_top
                             && P_ICR_TOP_MODES[evt_in[t].waveform_gen_sel]
                             |=> st.tmr[t].flag[SRC_CAP])
            else $error("top in capture-top mode did not set the capture flag");
         a_cap_vec_clear:
            assert property (vec_ack_in[t][SRC_CAP] && !set_vec[t][SRC_CAP] |=> !st.tmr[t].flag[SRC_CAP])
            else $error("capture flag survived its vector");
         a_cmp_c_delay:
            assert property ($rose(st.tmr[t].flag[SRC_CMP_C]) |-> $past(evt_in[t].tick && st.tmr[t].cmp_seen[2]))
            else $error("compare C flag rose outside the tick after a match");
         a_cmp_b_delay:
            assert property (evt_in[t].tick && evt_in[t].match[1] ##1 (!evt_in[t].tick)[*3]
                             ##1 evt_in[t].tick |=> st.tmr[t].flag[SRC_CMP_B])
            else $error("compare B flag not set at the next timer tick");
         a_cmp_a_delay:
            assert property (evt_in[t].tick && evt_in[t].match[0] ##1 !evt_in[t].tick ##1 evt_in[t].tick
                             |=> st.tmr[t].flag[SRC_CMP_A])
            else $error("compare A flag not set at the next timer tick");
         a_force_no_set:
            assert property (evt_in[t].force_cmp[0] && !st.tmr[t].flag[SRC_CMP_A]
                             && !(evt_in[t].tick && st.tmr[t].cmp_seen[0])
                             |=> !st.tmr[t].flag[SRC_CMP_A])
            else $error("forced compare set the compare A flag");
         a_cmp_w1c:
            assert property (flag_wr_ones[t][SRC_CMP_C] && !set_vec[t][SRC_CMP_C]
                             |=> !st.tmr[t].flag[SRC_CMP_C])
            else $error("writing one did not clear compare C flag");
         a_ovf_set:
            assert property (evt_in[t].tick && evt_in[t].overflow
                             && P_OVF_MAX_MODES[evt_in[t].waveform_gen_sel]
                             |=> st.tmr[t].flag[SRC_OVF])
            else $error("overflow in normal mode did not set the flag");
         a_ovf_clear:
            assert property ((vec_ack_in[t][SRC_OVF] || flag_wr_ones[t][SRC_OVF])
                             && !set_vec[t][SRC_OVF] |=> !st.tmr[t].flag[SRC_OVF])
            else $error("overflow flag survived its clear");
         a_zero_keeps:
            assert property (reg_hit(bus_in.addr, FLAG_OFS[t], bus_in.wr) && !bus_in.wdata[BIT_OVF]
                             && st.tmr[t].flag[SRC_OVF] && !vec_ack_in[t][SRC_OVF]
                             |=> st.tmr[t].flag[SRC_OVF])
            else $error("writing zero cleared the overflow flag");
         a_set_beats_clr:
            assert property (set_vec[t][SRC_CMP_B] && clr_vec[t][SRC_CMP_B] |=> st.tmr[t].flag[SRC_CMP_B])
            else $error("clear won over a simultaneous set");
      end
   endgenerate

   a_reserved_zero:
      assert property (bus_in.rd |=> (rd_data_out & RESERVED_BITS) == 8'h00)
      else $error("reserved bits read as one");

   a_read_mask_timer1:
      assert property (reg_hit(bus_in.addr, MASK_OFS[0], bus_in.rd)
                       |=> rd_data_out == to_reg($past(st.tmr[0].mask)))
      else $error("mask read data wrong");

endmodule

// ---- common/timer_irq_pkg.sv ----
// package: register map, field layout and carrier types of the timer interrupt mask and flag unit
//
// Overview of operation
// - capture request: mask bit 5, global, flag
// - compare C request: mask bit 3, global, flag
// - compare B request: mask bit 2, global, flag
// - compare A request: mask bit 1, global, flag
// - overflow request: mask bit 0, global, flag
// - capture pin event sets capture flag bit 5
// - capture register as top: top sets capture flag
// - capture flag cleared by vector or one
// - compare C flag set tick after match
// - compare B flag set tick after match
// - compare A flag set tick after match
// - forced compare never sets a match flag
// - match flags cleared by vector or one
// - overflow flag set per waveform mode
// - overflow flag cleared by vector or one
package timer_irq_pkg;

   localparam int N_TIMERS = 4;
   localparam int N_SRC    = 5;

   // source index inside the compact five-bit vectors
   localparam int SRC_OVF   = 0;
   localparam int SRC_CMP_A = 1;
   localparam int SRC_CMP_B = 2;
   localparam int SRC_CMP_C = 3;
   localparam int SRC_CAP   = 4;

   // bit positions inside the 8-bit mask and flag registers
   localparam int BIT_OVF     = 0;
   localparam int BIT_CMP_A   = 1;
   localparam int BIT_CMP_B   = 2;
   localparam int BIT_CMP_C   = 3;
   localparam int BIT_CAPTURE = 5;

   localparam logic [7:0] FLAG_OFS [N_TIMERS] = '{8'h36, 8'h38, 8'h39, 8'h3a};
   localparam logic [7:0] MASK_OFS [N_TIMERS] = '{8'h6f, 8'h71, 8'h72, 8'h73};
   localparam logic [7:0] OVR_STATUS_OFS      = 8'h7a;
   localparam logic [7:0] OVR_MASK_OFS        = 8'h7b;

   localparam logic [7:0] FLAG_RESET    = 8'h00;
   localparam logic [7:0] MASK_RESET    = 8'h00;
   localparam logic [7:0] RESERVED_BITS = 8'hd0;

   // waveform modes, one bit per waveform_gen_sel code
   localparam logic [15:0] OVF_MAX_MODES    = 16'h0011;
   localparam logic [15:0] OVF_TOP_MODES    = 16'hffee;
   localparam logic [15:0] OVF_BOTTOM_MODES = 16'h0000;
   localparam logic [15:0] ICR_TOP_MODES    = 16'h5500;

   typedef struct packed {
      logic       tick;             // one timer clock cycle
      logic       capture_pin;      // capture edge seen on capture_pin
      logic       at_top;           // counter_value equals top this tick
      logic       at_bottom;        // counter_value equals bottom this tick
      logic       overflow;         // counter_value wraps past max this tick
      logic [2:0] match;            // counter_value equals compare_reg_c/b/a
      logic [2:0] force_cmp;        // force_cmp_c/b/a strobes
      logic [3:0] waveform_gen_sel; // waveform generation setting
   } timer_evt_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;

   typedef struct packed {
      logic [N_SRC-1:0] mask;
      logic [N_SRC-1:0] flag;
      logic [2:0]       cmp_seen;
      logic [N_SRC-1:0] req;
   } unit_state_t;

   typedef struct packed {
      unit_state_t [N_TIMERS-1:0] tmr;
      logic [7:0]                 rd_data;
   } top_state_t;

   function automatic logic [7:0] to_reg(input logic [N_SRC-1:0] s);
      return {2'b00, s[SRC_CAP], 1'b0, s[SRC_CMP_C:SRC_OVF]};
   endfunction

   function automatic logic [N_SRC-1:0] from_reg(input logic [7:0] r);
      return {r[BIT_CAPTURE], r[BIT_CMP_C:BIT_OVF]};
   endfunction

   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs, input logic strobe);
      return strobe && (addr == ofs);
   endfunction

endpackage

// ---- core/irq_status_unit.sv ----
// sticky event status with write-one-to-clear, mask and one level interrupt
`timescale 1ns/100ps
module irq_status_unit #(
   parameter int W = 4
) (
   input  wire logic         ref_clk_in,  // system clock
   input  wire logic         reset_in,    // async reset, active high
   input  wire logic [W-1:0] set_in,      // event pulses
   input  wire logic         status_wr_in, // write strobe for status
   input  wire logic         mask_wr_in,  // write strobe for mask
   input  wire logic [W-1:0] wdata_in,    // write data
   output logic      [W-1:0] status_out,  // sticky status
   output logic      [W-1:0] mask_out,    // mask
   output logic              irq_out      // level interrupt
);
   typedef struct packed {
      logic [W-1:0] status;
      logic [W-1:0] mask;
      logic         irq;
   } stat_state_t;

   stat_state_t st;
   stat_state_t next_st;

   always_comb begin
      next_st = st;
      // set wins over a clear in the same cycle so no event is lost
      next_st.status = (st.status & ~(status_wr_in ? wdata_in : '0)) | set_in;
      if (mask_wr_in) begin
         next_st.mask = wdata_in;
      end
      next_st.irq = |(next_st.status & next_st.mask);
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign status_out = st.status;
   assign mask_out   = st.mask;
   assign irq_out    = st.irq;
endmodule

// ---- bench/irq_dispatch_model.sv ----
// processor dispatch model: executes one pending interrupt vector at a time while enabled
`timescale 1ns/100ps
module irq_dispatch_model (
   input  wire logic                                                          ref_clk_in,  // system clock
   input  wire logic                                                          reset_in,    // async reset
   input  wire logic                                                          enable_in,   // dispatch allowed
   input  wire logic [timer_irq_pkg::N_TIMERS-1:0][timer_irq_pkg::N_SRC-1:0] irq_req_in,  // pending requests
   output logic      [timer_irq_pkg::N_TIMERS-1:0][timer_irq_pkg::N_SRC-1:0] vec_ack_out  // vector executed
);
   import timer_irq_pkg::*;

   logic [1:0]                flat_hold;
   logic [N_TIMERS*N_SRC-1:0] flat;

   assign flat = irq_req_in;

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         flat_hold   <= 2'h0;
         vec_ack_out <= '0;
      end else begin
         vec_ack_out <= '0;
         if (flat_hold != 2'h0) begin
            // the request drops two cycles after the ack; wait it out to avoid a double dispatch
            flat_hold <= flat_hold - 2'h1;
         end else if (enable_in && (flat != '0)) begin
            vec_ack_out <= flat & (~flat + 1'b1);
            flat_hold   <= 2'h3;
         end
      end
   end
endmodule

// ---- bench/tb_top.sv ----
// self-checking testbench of the timer interrupt mask and flag unit
`timescale 1ns/100ps
module tb_top;
   import timer_irq_pkg::*;

   logic                           ref_clk_in;
   logic                           reset_in;
   logic                           glob_irq_en_in;
   logic                           dispatch_en;
   bus_req_t                       bus_in;
   timer_evt_t [N_TIMERS-1:0]      evt_in;
   logic [N_TIMERS-1:0][N_SRC-1:0] vec_ack;
   logic [N_TIMERS-1:0][N_SRC-1:0] irq_req;
   logic [7:0]                     rd_data;
   logic                           irq_out;
   int                             fails;
   int                             check_count;
   int                             cycles;
   int                             bp [5] = '{0, 1, 2, 3, 5};

   timer_irq_mask_flag_unit u_dut (
      .ref_clk_in     (ref_clk_in),
      .reset_in       (reset_in),
      .bus_in         (bus_in),
      .rd_data_out    (rd_data),
      .glob_irq_en_in (glob_irq_en_in),
      .evt_in         (evt_in),
      .vec_ack_in     (vec_ack),
      .irq_req_out    (irq_req),
      .irq_out        (irq_out)
   );

   irq_dispatch_model u_cpu (
      .ref_clk_in  (ref_clk_in),
      .reset_in    (reset_in),
      .enable_in   (dispatch_en),
      .irq_req_in  (irq_req),
      .vec_ack_out (vec_ack)
   );

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_in);
      bus_in.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so sample mid-cycle there
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk_in);
      bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_in);
      bus_in.rd <= 1'b0;
      @(negedge ref_clk_in);
      check(rd_data, exp, "register read");
   endtask

   function automatic timer_evt_t mk(logic tk, logic cap, logic top, logic ovf, logic [2:0] m, logic [2:0] f,
                                     logic [3:0] wg);
      return '{tick: tk, capture_pin: cap, at_top: top, at_bottom: 1'b0, overflow: ovf, match: m, force_cmp: f,
               waveform_gen_sel: wg};
   endfunction

   // one-cycle event pulse; the waveform setting is a level and stays
   task automatic ev(input int t, input timer_evt_t e);
      timer_evt_t idle;
      idle = '0;
      idle.waveform_gen_sel = e.waveform_gen_sel;
      @(posedge ref_clk_in);
      evt_in[t] <= e;
      @(posedge ref_clk_in);
      evt_in[t] <= idle;
   endtask

   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         $display("MISMATCH t=%0t run did not finish in time", $time);
         end_sim();
      end
   end

   initial begin
      logic [7:0] exp;
      reset_in       = 1'b1;
      bus_in         = '0;
      evt_in         = '0;
      glob_irq_en_in = 1'b0;
      dispatch_en    = 1'b0;
      repeat (10) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      for (int t = 0; t < N_TIMERS; t++) begin
         rdc(FLAG_OFS[t], 8'h00);
         rdc(MASK_OFS[t], 8'h00);
         wr(MASK_OFS[t], 8'hff);
         rdc(MASK_OFS[t], 8'h2f);
         wr(MASK_OFS[t], 8'h00);
      end
      wr(8'h40, 8'hff);
      rdc(8'h40, 8'h00);
      // flag setting per unit: force is ignored, matches land only on the following tick
      for (int t = 0; t < N_TIMERS; t++) begin
         ev(t, mk(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 3'h7, 4'h0));
         rdc(FLAG_OFS[t], 8'h00);
         ev(t, mk(1'b1, 1'b1, 1'b0, 1'b1, 3'h7, 3'h0, 4'h0));
         rdc(FLAG_OFS[t], 8'h21);
         ev(t, mk(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0, 4'h0));
         rdc(FLAG_OFS[t], 8'h2f);
         wr(FLAG_OFS[t], 8'h00);
         rdc(FLAG_OFS[t], 8'h2f);
         exp = 8'h2f;
         for (int i = 0; i < 5; i++) begin
            wr(FLAG_OFS[t], 8'h01 << bp[i]);
            exp &= ~(8'h01 << bp[i]);
            rdc(FLAG_OFS[t], exp);
         end
      end
      // every waveform setting: top and wrap events
      for (int m = 0; m < 16; m++) begin
         ev(2, mk(1'b1, 1'b0, 1'b1, 1'b1, 3'h0, 3'h0, m[3:0]));
         exp = {2'h0, ICR_TOP_MODES[m], 4'h0, OVF_TOP_MODES[m] | OVF_MAX_MODES[m]};
         rdc(FLAG_OFS[2], exp);
         wr(FLAG_OFS[2], 8'hff);
      end
      // a match that lands on the cycle of a write-one clear still sets the flag
      ev(0, mk(1'b1, 1'b0, 1'b0, 1'b0, 3'h2, 3'h0, 4'h0));
      fork
         wr(FLAG_OFS[0], 8'h04);
         ev(0, mk(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0, 4'h0));
      join
      rdc(FLAG_OFS[0], 8'h04);
      wr(FLAG_OFS[0], 8'h04);
      rdc(FLAG_OFS[0], 8'h00);
      // request gating by mask bit and global enable
      ev(1, mk(1'b1, 1'b1, 1'b0, 1'b1, 3'h7, 3'h0, 4'h0));
      ev(1, mk(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0, 4'h0));
      @(posedge ref_clk_in);
      glob_irq_en_in <= 1'b1;
      wr(MASK_OFS[1], 8'h2f);
      rdc(MASK_OFS[1], 8'h2f);
      check({3'h0, irq_req[1]}, 8'h1f, "all requests");
      for (int s = 0; s < 5; s++) begin
         wr(MASK_OFS[1], 8'h2f & ~(8'h01 << bp[s]));
         rdc(FLAG_OFS[1], 8'h2f);
         check({3'h0, irq_req[1]}, 8'h1f & ~(8'h01 << s), "masked request");
      end
      wr(MASK_OFS[1], 8'h2f);
      @(posedge ref_clk_in);
      glob_irq_en_in <= 1'b0;
      rdc(FLAG_OFS[1], 8'h2f);
      check({3'h0, irq_req[1]}, 8'h00, "global disable");
      // second capture while the flag is still set: lost-event interrupt masked, raised, cleared
      ev(1, mk(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 3'h0, 4'h0));
      rdc(OVR_STATUS_OFS, 8'h02);
      check({7'h0, irq_out}, 8'h00, "lost irq masked");
      wr(OVR_MASK_OFS, 8'h02);
      rdc(OVR_MASK_OFS, 8'h02);
      check({7'h0, irq_out}, 8'h01, "lost irq raised");
      wr(OVR_STATUS_OFS, 8'h02);
      rdc(OVR_STATUS_OFS, 8'h00);
      check({7'h0, irq_out}, 8'h00, "lost irq cleared");
      // vector dispatch clears every pending flag of the unit
      @(posedge ref_clk_in);
      glob_irq_en_in <= 1'b1;
      dispatch_en    <= 1'b1;
      // requests rise one cycle after the enable; look mid-cycle so the edge does not race the register
      repeat (2) @(negedge ref_clk_in);
      check({3'h0, irq_req[1]}, 8'h1f, "requests before dispatch");
      for (int n = 0; n < 60 && irq_req[1] !== 5'h00; n++) begin
         @(negedge ref_clk_in);
      end
      repeat (4) @(posedge ref_clk_in);
      rdc(FLAG_OFS[1], 8'h00);
      check({3'h0, irq_req[1]}, 8'h00, "requests after dispatch");
      end_sim();
   end
endmodule
